// *** design/test_probe_params.svh ***
// Constants for the test and probe pin controller: instruction codes,
// reset values and the scan reset figure.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TEST_PROBE_PARAMS_SVH
`define TEST_PROBE_PARAMS_SVH

// Instruction register width and codes
`define IR_W              2
`define IR_SAMPLE         2'h0
`define IR_PROBE_CFG      2'h2
`define IR_BYPASS         2'h3
// Fixed pattern loaded in capture-IR (low bits 01 as usual for scan)
`define IR_CAPTURE_VAL    2'h1
// Instruction after the scan logic reset state
`define IR_RESET_VAL      2'h3
// Width of the sample data register (the two probe pin levels)
`define SAMPLE_W          2
// Test clock cycles with mode-select high that reach logic reset
`define TCK_HIGH_TO_RESET 5
// Number of pins passed through the synchroniser
`define PIN_SYNC_W        6

`endif

// *** design/test_probe_pkg.sv ***
// Types for the test and probe pin controller.
// Assumes the constants header is on the include path.
`include "test_probe_params.svh"

package test_probe_pkg;

	// Scan controller states, as the standard test access port has them
	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} tap_state_e;

	// Instruction register contents
	typedef logic [`IR_W-1:0] instr_t;

endpackage

// *** design/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clk_sys_i; only stage two is read.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int W = 1
) (
	// Clock, reset, enable
	input  wire logic         clk_sys_i,
	input  wire logic         resetn_i,
	input  wire logic         clk_en_i,
	// Raw and synchronised levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	// Refuse an empty group
	if (W < 1) begin : g_bad_width
		$error("pin_sync: W must be at least 1");
	end

	// One pair of flops per pin; first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_ff;
		logic sync_ff;
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				meta_ff <= 1'b0;
				sync_ff <= 1'b0;
			end else if (clk_en_i) begin
				meta_ff <= d_i[i];
				sync_ff <= meta_ff;
			end
		end
		assign q_o[i] = sync_ff;
	end

endmodule

`default_nettype wire

// *** design/test_probe_pin_control.sv ***
// Shared test and probe pin controller: scan controller on the test clock
// pin, pin role switching, and two probe pins with a lock that reset clears unless the fuse is blown.
// Assumes all pins are asynchronous and the test clock is much slower
// than clk_sys_i (at least four system clocks per test clock phase).
`timescale 1ns/100ps
`default_nettype none
`include "test_probe_params.svh"

module test_probe_pin_control #(
	parameter int NODE_W = 16
) (
	// Clock, reset, enable
	input  wire logic              clk_sys_i,
	input  wire logic              resetn_i,
	input  wire logic              clk_en_i,
	// Configuration levels
	input  wire logic              dedicated_mode_i,
	input  wire logic              probe_fuse_i,
	input  wire logic              probe_lock_i,
	// Internal nodes offered to the probes
	input  wire logic [NODE_W-1:0] node_i,
	// Scan pins
	input  wire logic              tck_pin_i,
	input  wire logic              tms_pin_i,
	input  wire logic              tdi_pin_i,
	input  wire logic              tdo_pin_i,
	output logic                   tdo_pin_o,
	output logic                   tdo_pin_oe_n_o,
	// Probe pins
	input  wire logic              probe_pin_first_i,
	output logic                   probe_pin_first_o,
	output logic                   probe_pin_first_oe_n_o,
	input  wire logic              probe_pin_second_i,
	output logic                   probe_pin_second_o,
	output logic                   probe_pin_second_oe_n_o,
	// User logic side of shared pins
	output logic                   user_tck_o,
	output logic                   user_tdi_o,
	output logic                   user_tdo_in_o,
	input  wire logic              user_tdo_i,
	input  wire logic              user_tdo_oe_i,
	output logic                   user_probe_first_in_o,
	input  wire logic              user_probe_first_i,
	input  wire logic              user_probe_first_oe_i,
	output logic                   user_probe_second_in_o,
	input  wire logic              user_probe_second_i,
	input  wire logic              user_probe_second_oe_i,
	// Status
	output logic                   scan_active_o,
	output test_probe_pkg::tap_state_e tap_state_o,
	output logic                   probe_locked_o,
	output logic [1:0]             probe_active_o
);
	import test_probe_pkg::*;

	localparam int SEL_W = $clog2(NODE_W);
	localparam int CFG_W = 2 * (SEL_W + 1);
	localparam int DR_W  = CFG_W;

	// Node count must index cleanly with the select field
	if (NODE_W < 2 || NODE_W > 1024 || (NODE_W & (NODE_W - 1)) != 0) begin : g_bad_node
		$error("test_probe_pin_control: NODE_W must be a power of two, 2..1024");
	end

	// Synchronised pin levels
	logic [`PIN_SYNC_W-1:0] pin_s;
	logic                   tck_s;
	logic                   tms_s;
	logic                   tdi_s;
	logic                   tdo_s;
	logic [1:0]             prb_s;

	pin_sync #(
		.W (`PIN_SYNC_W)
	) u_pin_sync (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.clk_en_i  (clk_en_i),
		.d_i       ({probe_pin_second_i, probe_pin_first_i, tdo_pin_i,
		              tdi_pin_i, ~tms_pin_i, tck_pin_i}),
		.q_o       (pin_s)
	);

	assign tck_s = pin_s[0];
	// Mode-select crosses inverted: a cleared synchroniser must read as
	// idle high, or reset release would look like a low level and grab pins
	assign tms_s = ~pin_s[1];
	assign tdi_s = pin_s[2];
	assign tdo_s = pin_s[3];
	assign prb_s = pin_s[5:4];

	// Test clock edge finder on the synchronised level
	logic tck_d_ff;
	logic tck_rise;
	logic tck_fall;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tck_d_ff <= 1'b0;
		end else if (clk_en_i) begin
			tck_d_ff <= tck_s;
		end
	end

	assign tck_rise = tck_s & ~tck_d_ff;
	assign tck_fall = ~tck_s & tck_d_ff;

	// Standard scan controller next state
	function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
		tap_state_e n;
		n = s;
		case (s)
			TAP_RESET:    n = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     n = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   n = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: n = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: n = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   n = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: n = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: n = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
			default:      n = TAP_RESET;
		endcase
		return n;
	endfunction

	// Scan path steps only while the pins belong to it; in flexible mode a
	// low mode-select also counts, so the first edge after it is not lost
	logic       scan_active_ff;
	logic       scan_enable;
	logic       tap_step;
	tap_state_e tap_ff;
	tap_state_e nxt_tap;
	logic       enters_reset;

	assign scan_enable  = dedicated_mode_i | scan_active_ff | ~tms_s;
	assign tap_step     = tck_rise & scan_enable;
	assign nxt_tap      = tap_next(tap_ff, tms_s);
	assign enters_reset = tap_step & (tap_ff != TAP_RESET) & (nxt_tap == TAP_RESET);

	// Controller state; five high mode-select clocks reach reset from anywhere
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tap_ff <= TAP_RESET;
		end else if (clk_en_i && tap_step) begin
			tap_ff <= nxt_tap;
		end
	end

	// Pin role: dedicated mode holds scan use for good
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scan_active_ff <= 1'b0;
		end else if (clk_en_i) begin
			if (dedicated_mode_i) begin
				scan_active_ff <= 1'b1;
			end else if (scan_active_ff) begin
				scan_active_ff <= ~enters_reset;
			end else begin
				scan_active_ff <= ~tms_s;
			end
		end
	end

	// Probe lock: once set, only a full reset clears the soft copy;
	// the fuse input itself never lets go
	logic lock_ff;
	logic locked;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lock_ff <= 1'b0;
		end else if (clk_en_i && (probe_lock_i || probe_fuse_i)) begin
			lock_ff <= 1'b1;
		end
	end

	assign locked = lock_ff | probe_fuse_i;

	// Instruction register path
	instr_t ir_ff;
	instr_t ir_sh_ff;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ir_ff    <= `IR_RESET_VAL;
			ir_sh_ff <= `IR_CAPTURE_VAL;
		end else if (clk_en_i && tap_step) begin
			case (tap_ff)
				TAP_RESET:    ir_ff <= `IR_RESET_VAL;
				TAP_CAP_IR:   ir_sh_ff <= `IR_CAPTURE_VAL;
				TAP_SHIFT_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`IR_W-1:1]};
				TAP_UPD_IR:   ir_ff <= ir_sh_ff;
				default:      ir_ff <= ir_ff;
			endcase
		end
	end

	// Data register length follows the current instruction
	logic [DR_W-1:0]  dr_sh_ff;
	logic [DR_W-1:0]  dr_shifted;
	logic [CFG_W-1:0] cfg_ff;
	int unsigned      dr_len;

	always_comb begin
		dr_len = 1;
		case (ir_ff)
			`IR_SAMPLE:    dr_len = `SAMPLE_W;
			`IR_PROBE_CFG: dr_len = CFG_W;
			default:       dr_len = 1;
		endcase
	end

	// Serial data enters at the far end of the selected length
	always_comb begin
		dr_shifted = '0;
		for (int i = 0; i < DR_W; i++) begin
			if (i == int'(dr_len) - 1) begin
				dr_shifted[i] = tdi_s;
			end else if (i < DR_W - 1) begin
				dr_shifted[i] = dr_sh_ff[i+1];
			end
		end
	end

	// Data register capture and shift
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dr_sh_ff <= '0;
		end else if (clk_en_i && tap_step) begin
			if (tap_ff == TAP_CAP_DR) begin
				case (ir_ff)
					`IR_SAMPLE:    dr_sh_ff <= DR_W'(prb_s);
					`IR_PROBE_CFG: dr_sh_ff <= DR_W'(cfg_ff);
					default:       dr_sh_ff <= '0;
				endcase
			end else if (tap_ff == TAP_SHIFT_DR) begin
				dr_sh_ff <= dr_shifted;
			end
		end
	end

	// Probe routing set up over scan; refused and wiped while locked
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_ff <= '0;
		end else if (clk_en_i) begin
			if (locked) begin
				cfg_ff <= '0;
			end else if (tap_step && tap_ff == TAP_UPD_DR && ir_ff == `IR_PROBE_CFG) begin
				cfg_ff <= dr_sh_ff[CFG_W-1:0];
			end
		end
	end

	// Serial output changes on the falling test clock edge
	logic tdo_data_ff;
	logic tdo_drive_ff;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdo_data_ff  <= 1'b0;
			tdo_drive_ff <= 1'b0;
		end else if (clk_en_i && tck_fall && scan_enable) begin
			tdo_data_ff  <= (tap_ff == TAP_SHIFT_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
			tdo_drive_ff <= (tap_ff == TAP_SHIFT_IR) || (tap_ff == TAP_SHIFT_DR);
		end
	end

	// Shared scan pins: scan owns them while active, else user logic
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdo_pin_o      <= 1'b0;
			tdo_pin_oe_n_o <= 1'b1;
			user_tck_o     <= 1'b0;
			user_tdi_o     <= 1'b0;
			user_tdo_in_o  <= 1'b0;
		end else if (clk_en_i) begin
			if (scan_active_ff) begin
				tdo_pin_o      <= tdo_data_ff;
				tdo_pin_oe_n_o <= ~tdo_drive_ff;
				user_tck_o     <= 1'b0;
				user_tdi_o     <= 1'b0;
				user_tdo_in_o  <= 1'b0;
			end else begin
				tdo_pin_o      <= user_tdo_i;
				tdo_pin_oe_n_o <= ~user_tdo_oe_i;
				user_tck_o     <= tck_s;
				user_tdi_o     <= tdi_s;
				user_tdo_in_o  <= tdo_s;
			end
		end
	end

	// Probe pins, one slice each; cfg holds {en, sel} per probe
	logic [1:0] user_prb_o;
	logic [1:0] user_prb_oe;
	logic [1:0] prb_o_ff;
	logic [1:0] prb_oe_n_ff;
	logic [1:0] prb_in_ff;
	logic [1:0] prb_on;

	assign user_prb_o  = {user_probe_second_i, user_probe_first_i};
	assign user_prb_oe = {user_probe_second_oe_i, user_probe_first_oe_i};

	for (genvar k = 0; k < 2; k++) begin : g_probe
		logic [SEL_W-1:0] sel;
		assign sel       = cfg_ff[k*(SEL_W+1) +: SEL_W];
		assign prb_on[k] = cfg_ff[k*(SEL_W+1) + SEL_W] & ~locked;

		// Live node, one system clock late; user drive otherwise
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				prb_o_ff[k]    <= 1'b0;
				prb_oe_n_ff[k] <= 1'b1;
				prb_in_ff[k]   <= 1'b0;
			end else if (clk_en_i) begin
				prb_in_ff[k] <= prb_s[k];
				if (prb_on[k]) begin
					prb_o_ff[k]    <= node_i[sel];
					prb_oe_n_ff[k] <= 1'b0;
				end else begin
					prb_o_ff[k]    <= user_prb_o[k];
					prb_oe_n_ff[k] <= ~user_prb_oe[k];
				end
			end
		end
	end

	// Port hookup
	assign probe_pin_first_o       = prb_o_ff[0];
	assign probe_pin_first_oe_n_o  = prb_oe_n_ff[0];
	assign probe_pin_second_o      = prb_o_ff[1];
	assign probe_pin_second_oe_n_o = prb_oe_n_ff[1];
	assign user_probe_first_in_o   = prb_in_ff[0];
	assign user_probe_second_in_o  = prb_in_ff[1];

	// Status
	assign scan_active_o  = scan_active_ff;
	assign tap_state_o    = tap_ff;
	assign probe_locked_o = locked;
	assign probe_active_o = prb_on;

endmodule

`default_nettype wire

// *** tb/test_probe_pin_control_properties.sv ***
// Checker for the test and probe pin controller, bound to its top.
// Assumes clk_en_i stays high while the checker watches.
`timescale 1ns/100ps
`default_nettype none

module test_probe_pin_control_properties
	import test_probe_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       resetn_i,
	// Inputs watched
	input wire logic       dedicated_mode_i,
	input wire logic       probe_fuse_i,
	input wire logic       probe_lock_i,
	input wire logic       tms_pin_i,
	input wire logic       user_tdo_i,
	input wire logic       user_tdo_oe_i,
	input wire logic       user_probe_first_i,
	input wire logic       user_probe_first_oe_i,
	// Outputs watched
	input wire logic       tdo_pin_o,
	input wire logic       tdo_pin_oe_n_o,
	input wire logic       probe_pin_first_o,
	input wire logic       probe_pin_first_oe_n_o,
	input wire logic       user_tck_o,
	input wire logic       user_tdi_o,
	input wire logic       scan_active_o,
	input wire tap_state_e tap_state_o,
	input wire logic       probe_locked_o,
	input wire logic [1:0] probe_active_o
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	// Pin role switching
	property p_enter_scan;
		(!tms_pin_i) [*5] |-> scan_active_o;
	endproperty
	a_enter_scan: assert property (p_enter_scan) else $error("scan use not entered");
	property p_hold_scan;
		scan_active_o && tap_state_o != TAP_RESET |=> scan_active_o || tap_state_o == TAP_RESET;
	endproperty
	a_hold_scan: assert property (p_hold_scan) else $error("scan use left early");
	property p_release;
		$rose(tap_state_o == TAP_RESET) && !dedicated_mode_i |-> ##[1:2] !scan_active_o;
	endproperty
	a_release: assert property (p_release) else $error("pins not released");
	property p_user_tdo;
		(!scan_active_o && !dedicated_mode_i) [*2] ##0 user_tdo_oe_i
			|=> !tdo_pin_oe_n_o && tdo_pin_o == $past(user_tdo_i);
	endproperty
	a_user_tdo: assert property (p_user_tdo) else $error("data-out pin not user");
	property p_dedicated;
		dedicated_mode_i |=> scan_active_o;
	endproperty
	a_dedicated: assert property (p_dedicated) else $error("dedicated fell back");
	property p_user_off;
		scan_active_o |=> !user_tck_o && !user_tdi_o;
	endproperty
	a_user_off: assert property (p_user_off) else $error("scan pins leak to user");

	// Probe pins and the lock
	property p_probe_first;
		probe_active_o[0] && !probe_lock_i && !probe_fuse_i |=> !probe_pin_first_oe_n_o;
	endproperty
	a_probe_first: assert property (p_probe_first) else $error("probe not driving");
	property p_user_probe;
		probe_locked_o [*3] ##0 user_probe_first_oe_i
			|=> !probe_pin_first_oe_n_o && probe_pin_first_o == $past(user_probe_first_i);
	endproperty
	a_user_probe: assert property (p_user_probe) else $error("probe pin not user");
	property p_lock_sticky;
		probe_lock_i |=> probe_locked_o [*8];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock not kept");
	property p_lock_kills;
		probe_locked_o |-> probe_active_o == 2'h0;
	endproperty
	a_lock_kills: assert property (p_lock_kills) else $error("probe alive when locked");
endmodule

bind test_probe_pin_control test_probe_pin_control_properties chk_i (
	.clk_sys_i, .resetn_i, .dedicated_mode_i, .probe_fuse_i, .probe_lock_i, .tms_pin_i,
	.user_tdo_i, .user_tdo_oe_i, .user_probe_first_i, .user_probe_first_oe_i, .tdo_pin_o,
	.tdo_pin_oe_n_o, .probe_pin_first_o, .probe_pin_first_oe_n_o, .user_tck_o, .user_tdi_o,
	.scan_active_o, .tap_state_o, .probe_locked_o, .probe_active_o
);
`default_nettype wire

// *** tb/scan_ctl_model.sv ***
// Model of the far-side scan controller driving the test pins.
// Assumes calls start at a falling system clock edge; test clock idles low.
`timescale 1ns/100ps
`default_nettype none

module scan_ctl_model (
	// Pacing clock
	input wire logic clk_sys_i,
	// Scan pins
	output logic     tck_o,
	output logic     tms_o,
	output logic     tdi_o,
	input wire logic tdo_i
);
	// Idle with mode-select high so pins stay user I/O
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// One 320 ns test clock; data-out taken just before the rise
	task automatic step(input logic ms, input logic din, output logic dout);
		tms_o = ms;
		tdi_o = din;
		repeat (4) @(negedge clk_sys_i);
		dout = tdo_i;
		tck_o = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		tck_o = 1'b0;
	endtask

	// From idle: shift n bits LSB first into IR or DR, back to idle
	task automatic access(input logic ir, input int n, input logic [15:0] d,
			output logic [15:0] q);
		logic b;
		q = '0;
		step(1'b1, 1'b0, b);
		if (ir) begin
			step(1'b1, 1'b0, b);
		end
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], b);
			q[i] = b;
		end
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask
endmodule
`default_nettype wire

// *** tb/test_probe_pin_control_tb_top.sv ***
// Bench for the test and probe pin controller with a scan controller model.
// Assumes the checker binds itself; idle pins read high through pull-ups.
`timescale 1ns/100ps
`default_nettype none

module test_probe_pin_control_tb_top;
	import test_probe_pkg::*;

	// Design inputs
	logic        clk_sys_i, resetn_i, clk_en_i, dedicated_mode_i, probe_fuse_i;
	logic        probe_lock_i, tck_pin_i, tms_pin_i, tdi_pin_i, user_tdo_i, user_tdo_oe_i;
	logic        user_probe_first_i, user_probe_first_oe_i;
	logic        user_probe_second_i, user_probe_second_oe_i;
	logic [15:0] node_i;
	// Design outputs
	logic        tdo_pin_o, tdo_pin_oe_n_o, probe_pin_first_o, probe_pin_first_oe_n_o;
	logic        probe_pin_second_o, probe_pin_second_oe_n_o, user_tck_o, user_tdi_o;
	logic        user_tdo_in_o, user_probe_first_in_o, user_probe_second_in_o;
	logic        scan_active_o, probe_locked_o;
	logic [1:0]  probe_active_o;
	tap_state_e  tap_state_o;
	// Pin levels: released pins pulled up
	wire         tdo_pin_i = tdo_pin_oe_n_o ? 1'b1 : tdo_pin_o;
	wire         probe_pin_first_i = probe_pin_first_oe_n_o ? 1'b1 : probe_pin_first_o;
	wire         probe_pin_second_i = probe_pin_second_oe_n_o ? 1'b1 : probe_pin_second_o;
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;

	// Block under test and far-side controller
	test_probe_pin_control #(.NODE_W(16)) dut (
		.clk_sys_i, .resetn_i, .clk_en_i, .dedicated_mode_i, .probe_fuse_i, .probe_lock_i,
		.node_i, .tck_pin_i, .tms_pin_i, .tdi_pin_i, .tdo_pin_i, .tdo_pin_o, .tdo_pin_oe_n_o,
		.probe_pin_first_i, .probe_pin_first_o, .probe_pin_first_oe_n_o, .probe_pin_second_i,
		.probe_pin_second_o, .probe_pin_second_oe_n_o, .user_tck_o, .user_tdi_o,
		.user_tdo_in_o, .user_tdo_i, .user_tdo_oe_i, .user_probe_first_in_o,
		.user_probe_first_i, .user_probe_first_oe_i, .user_probe_second_in_o,
		.user_probe_second_i, .user_probe_second_oe_i, .scan_active_o, .tap_state_o,
		.probe_locked_o, .probe_active_o
	);
	scan_ctl_model ctl (.clk_sys_i, .tck_o(tck_pin_i), .tms_o(tms_pin_i),
		.tdi_o(tdi_pin_i), .tdo_i(tdo_pin_i));

	// 25 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// Cut a hang short; whole run needs about 800 cycles
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Reset state, then test clocks with mode-select high are ignored
	task automatic t_reset();
		logic b;
		chk({scan_active_o, tdo_pin_oe_n_o}, 2'b01);
		chk(tap_state_o, TAP_RESET);
		chk(probe_pin_first_oe_n_o, 1'b1);
		repeat (3) ctl.step(1'b1, 1'b0, b);
		chk(tap_state_o, TAP_RESET);
		chk(scan_active_o, 1'b0);
		chk(user_tdo_in_o, 1'b1);
		chk(user_probe_second_in_o, 1'b1);
		// Clock and data-in high with mode-select high reach the user side
		ctl.tdi_o = 1'b1;
		ctl.tck_o = 1'b1;
		tick(4);
		chk({user_tck_o, user_tdi_o}, 2'b11);
		chk(tap_state_o, TAP_RESET);
		ctl.tck_o = 1'b0;
		ctl.tdi_o = 1'b0;
		tick(4);
		$display("reset test done");
	endtask

	// Enter scan use, hold through four high clocks, release on the fifth
	task automatic t_enter();
		logic b;
		user_tdo_oe_i = 1'b1;
		ctl.step(1'b0, 1'b0, b);
		chk(scan_active_o, 1'b1);
		chk(tap_state_o, TAP_IDLE);
		// Data shift is one of the states farthest from reset: five clocks needed
		ctl.step(1'b1, 1'b0, b);
		repeat (2) ctl.step(1'b0, 1'b0, b);
		chk(tap_state_o, TAP_SHIFT_DR);
		repeat (4) ctl.step(1'b1, 1'b0, b);
		chk(scan_active_o, 1'b1);
		chk(tap_state_o == TAP_RESET, 1'b0);
		ctl.step(1'b1, 1'b0, b);
		chk(tap_state_o, TAP_RESET);
		tick(3);
		chk(scan_active_o, 1'b0);
		user_tdo_i = 1'b1;
		tick(2);
		chk({tdo_pin_oe_n_o, tdo_pin_o}, 2'b01);
		$display("enter and release test done");
	endtask

	// Program both probes over scan, read back, then watch nodes
	task automatic t_probe();
		logic b;
		logic [15:0] q;
		logic [15:0] pat [4] = '{16'h0020, 16'h0400, 16'hfbdf, 16'h0000};
		ctl.step(1'b0, 1'b0, b);
		ctl.access(1'b1, 2, 16'h0002, q);
		chk(q[1:0], 2'h1);
		ctl.access(1'b0, 10, 16'h0355, q);
		chk(q[9:0], 10'h000);
		tick(2);
		chk(probe_active_o, 2'b11);
		ctl.access(1'b0, 10, 16'h0355, q);
		chk(q[9:0], 10'h355);
		repeat (5) ctl.step(1'b1, 1'b0, b);
		tick(4);
		chk(scan_active_o, 1'b0);
		foreach (pat[i]) begin
			node_i = pat[i];
			tick(2);
			chk(probe_pin_first_o, pat[i][5]);
			chk(probe_pin_second_o, pat[i][10]);
			chk({probe_pin_second_oe_n_o, probe_pin_first_oe_n_o}, 2'b00);
		end
		$display("probe test done");
	endtask

	// Lock the probes, pins turn to user I/O, later routing refused
	task automatic t_lock();
		logic b;
		logic [15:0] q;
		user_probe_first_i = 1'b1;
		user_probe_first_oe_i = 1'b1;
		user_probe_second_oe_i = 1'b1;
		probe_lock_i = 1'b1;
		tick(1);
		probe_lock_i = 1'b0;
		chk(probe_locked_o, 1'b1);
		tick(4);
		chk(probe_active_o, 2'b00);
		chk({probe_pin_first_oe_n_o, probe_pin_first_o}, 2'b01);
		chk({probe_pin_second_oe_n_o, probe_pin_second_o}, 2'b00);
		chk(user_probe_first_in_o, 1'b1);
		ctl.step(1'b0, 1'b0, b);
		ctl.access(1'b1, 2, 16'h0002, q);
		ctl.access(1'b0, 10, 16'h0355, q);
		chk(q[9:0], 10'h000);
		repeat (5) ctl.step(1'b1, 1'b0, b);
		chk(probe_active_o, 2'b00);
		$display("lock test done");
	endtask

	// Second reset with the fuse blown, then dedicated scan mode
	task automatic t_ded();
		logic b;
		resetn_i = 1'b0;
		probe_fuse_i = 1'b1;
		tick(8);
		resetn_i = 1'b1;
		tick(1);
		chk(probe_locked_o, 1'b1);
		dedicated_mode_i = 1'b1;
		tick(2);
		chk(scan_active_o, 1'b1);
		ctl.step(1'b0, 1'b0, b);
		chk(tap_state_o, TAP_IDLE);
		ctl.step(1'b1, 1'b0, b);
		chk(tap_state_o, TAP_SEL_DR);
		repeat (5) ctl.step(1'b1, 1'b0, b);
		tick(4);
		chk(tap_state_o, TAP_RESET);
		chk(scan_active_o, 1'b1);
		$display("dedicated test done");
	endtask

	// Main sequence
	initial begin
		{resetn_i, dedicated_mode_i, probe_fuse_i, probe_lock_i} = 4'h0;
		{user_tdo_i, user_tdo_oe_i, user_probe_first_i, user_probe_first_oe_i} = 4'h0;
		{user_probe_second_i, user_probe_second_oe_i} = 2'h0;
		clk_en_i = 1'b1;
		node_i = 16'h0000;
		tick(8);
		resetn_i = 1'b1;
		tick(2);
		t_reset();
		t_enter();
		t_probe();
		t_lock();
		t_ded();
		close_out();
	end
endmodule
`default_nettype wire
